//--- verilog/sar_adc_pkg.sv
// sar_adc_pkg: register map, field layout, reset values, timing counts and
// state encoding of the successive-approximation converter sequencer.
// assumes a 125 MHz system clock and a 32-bit AHB-Lite register port.
package sar_adc_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // register byte offsets, decoded over the low address bits
  localparam int AW = 8;
  localparam logic [AW-1:0] OFF_CTRL0 = 8'h00;
  localparam logic [AW-1:0] OFF_CTRL1 = 8'h04;
  localparam logic [AW-1:0] OFF_RES_HI = 8'h08;
  localparam logic [AW-1:0] OFF_RES_LO = 8'h0c;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [AW-1:0] OFF_NONE = 8'hfc;

  localparam int DW = 32;
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic HRESP_OKAY = 1'b0;

  // converter_control_0 fields
  localparam int C0_EN_BIT = 0;
  localparam int C0_GO_BIT = 1;
  localparam int C0_CHAN_LSB = 2;
  localparam int CHAN_W = 4;
  // converter_control_1 fields
  localparam int C1_CS_LSB = 0;
  localparam int CS_W = 3;
  localparam int C1_REF_BIT = 4;
  localparam logic [1:0] CS_OSC = 2'b11;

  // result layout: right justified, low byte in result_low
  localparam int RES_W = 10;
  localparam int RES_LO_W = 8;
  localparam int RES_HI_W = RES_W - RES_LO_W;

  // channel map: codes below NUM_PINS are pins, then temperature and fixed ref
  localparam int NUM_CHAN = 16;
  localparam int NUM_PINS = 14;
  localparam logic [NUM_PINS-1:0] PIN_MASK = 14'h0f1f;

  // interrupt status and mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OSC = 1;

  // reset values
  localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;
  localparam logic [CS_W-1:0] CS_RST = 3'b000;
  localparam logic REF_RST = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'b00;

  // conversion phases in half bit-periods: 2 hold, 20 resolve, 1 store = 23
  localparam int PH_W = 5;
  localparam logic [PH_W-1:0] PH_HOLD_END = 5'd1;
  localparam logic [PH_W-1:0] PH_LAST = 5'd22;
  localparam logic [RES_W-1:0] SAR_FIRST = 10'h200;
  localparam logic [3:0] BIT_MSB = 4'd9;
  localparam logic [3:0] BIT_LSB = 4'd0;

  // dedicated oscillator bit period window, checked per half period
  localparam int OSC_PERIOD_MIN_NS = 1000;
  localparam int OSC_PERIOD_MAX_NS = 6000;
  localparam int OSC_HALF_MIN_CYC = (OSC_PERIOD_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_HALF_MAX_CYC = (OSC_PERIOD_MAX_NS / 2) / CLK_PERIOD_NS;
  localparam int OSC_CNT_W = 9;
  localparam logic [OSC_CNT_W-1:0] OSC_MIN_CNT = 9'(OSC_HALF_MIN_CYC - 1);
  localparam logic [OSC_CNT_W-1:0] OSC_MAX_CNT = 9'(OSC_HALF_MAX_CYC - 1);

  localparam int DIV_W = 6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RESOLVE = 2'b10
  } conv_state_t;

endpackage : sar_adc_pkg

//--- verilog/sar_tick_gen.sv
// sar_tick_gen: half bit-period tick source for the converter sequencer.
// assumes convOsc is the dedicated oscillator as a level synchronous to clk_sys.
`timescale 1ns/1ps
module sar_tick_gen (
  input wire logic clk_sys,
  input wire logic rstSyncN,
  input wire logic run,
  input wire logic [sar_adc_pkg::CS_W-1:0] clockSel,
  input wire logic convOsc,
  input wire logic sleeping,
  output logic halfTick,
  output logic oscFault
);
  import sar_adc_pkg::*;

  logic [DIV_W-1:0] divCnt_reg, divCnt_next;
  logic [OSC_CNT_W-1:0] oscCnt_reg, oscCnt_next;
  logic oscPrev_reg, oscPrev_next;
  logic oscSeen_reg, oscSeen_next;
  logic tick_reg, tick_next;
  logic fault_reg, fault_next;
  logic useOsc;
  logic oscEdge;
  logic [DIV_W-1:0] halfDiv;

  always_comb begin
    useOsc = clockSel[1:0] == CS_OSC;
    // code bits [1:0] pick /2, /8, /32 and bit 2 doubles it: half period 1..32
    halfDiv = DIV_W'(6'h01 << ({1'b0, clockSel[1:0], 1'b0} + {3'b000, clockSel[2]}));
    oscEdge = convOsc != oscPrev_reg;
    oscPrev_next = convOsc;
    divCnt_next = divCnt_reg;
    oscCnt_next = oscCnt_reg;
    oscSeen_next = oscSeen_reg;
    tick_next = 1'b0;
    fault_next = 1'b0;
    if (!run) begin
      divCnt_next = '0;
      oscCnt_next = '0;
      oscSeen_next = 1'b0;
    end else if (useOsc) begin
      // the oscillator keeps running in sleep and ignores the system clock rate
      if (oscEdge) begin
        tick_next = 1'b1;
        oscCnt_next = '0;
        oscSeen_next = 1'b1;
        fault_next = oscSeen_reg && (oscCnt_reg < OSC_MIN_CNT || oscCnt_reg > OSC_MAX_CNT);
      end else begin
        if (oscCnt_reg != '1) begin
          oscCnt_next = oscCnt_reg + 1'b1;
        end
        // a dead oscillator is reported once instead of hanging silently
        fault_next = oscCnt_reg == OSC_MAX_CNT + 1'b1;
      end
    end else if (!sleeping) begin
      // system clock derived ticks stop while the core sleeps
      if (divCnt_reg == halfDiv - 1'b1) begin
        divCnt_next = '0;
        tick_next = 1'b1;
      end else begin
        divCnt_next = divCnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      divCnt_reg <= '0;
      oscCnt_reg <= '0;
      oscPrev_reg <= 1'b0;
      oscSeen_reg <= 1'b0;
      tick_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_next;
      oscCnt_reg <= oscCnt_next;
      oscPrev_reg <= oscPrev_next;
      oscSeen_reg <= oscSeen_next;
      tick_reg <= tick_next;
      fault_reg <= fault_next;
    end
  end

  assign halfTick = tick_reg;
  assign oscFault = fault_reg;

endmodule : sar_tick_gen

//--- verilog/sar_adc_sequencer.sv
// sar_adc_sequencer: 10-bit successive-approximation converter control with
// channel and reference selection, conversion clock choice and completion irq.
// assumes a single AHB-Lite master, an analog comparator on compIn (high when
// the input is above dacCode) and all inputs synchronous to clk_sys.
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - resolve held input to 10-bit code, store in result_high/result_low at end
// - up to 11 inputs: analog pins, temperature indicator, fixed voltage reference
// - only the input named by channel_select reaches the sample-and-hold
// - positive reference is the reference pin or supply, per pos_ref_select
// - conv_clock_select: 000/2 100/4 001/8 101/16 010/32 110/64, x11 dedicated osc
// - one conversion takes 11.5 bit-conversion periods of the selected clock
// - completion raises an interrupt that can wake the core from sleep
// - in sleep only the dedicated oscillator runs conversions; software selects it
// - divided clocks track the system clock frequency
// - dedicated oscillator period typically 1.6 us, within 1.0 to 6.0 us
module sar_adc_sequencer (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [sar_adc_pkg::DW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [sar_adc_pkg::DW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [sar_adc_pkg::DW-1:0] hrdata,
  input wire logic compIn,
  input wire logic convOsc,
  input wire logic sleeping,
  output logic [sar_adc_pkg::NUM_CHAN-1:0] chanSel,
  output logic posRefSel,
  output logic sampleEn,
  output logic [sar_adc_pkg::RES_W-1:0] dacCode,
  output logic busy,
  output logic irq,
  output logic wakeReq
);
  import sar_adc_pkg::*;

  // reset release through two flops
  logic rstPipe_reg;
  logic rstSyncN;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstPipe_reg <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstPipe_reg <= 1'b1;
      rstSyncN <= rstPipe_reg;
    end
  end

  // bus slave state
  logic [AW-1:0] addr_reg, addr_next;
  logic wrPend_reg, wrPend_next;
  logic rdPend_reg, rdPend_next;
  logic [DW-1:0] hrdata_reg, hrdata_next;
  logic [DW-1:0] readMux;
  logic accept;
  logic wrCtrl0, wrCtrl1, wrMask, rdClr;

  // software controls
  logic enable_reg, enable_next;
  logic go_reg, go_next;
  logic [CHAN_W-1:0] chan_reg, chan_next;
  logic [CS_W-1:0] cs_reg, cs_next;
  logic ref_reg, ref_next;
  logic [IRQ_W-1:0] mask_reg, mask_next;
  logic [IRQ_W-1:0] status_reg, status_next;
  logic [IRQ_W-1:0] irqSet;

  // conversion state
  conv_state_t state_reg, state_next;
  logic [PH_W-1:0] phase_reg, phase_next;
  logic [3:0] bitIdx_reg, bitIdx_next;
  logic [RES_W-1:0] sar_reg, sar_next;
  logic [RES_W-1:0] result_reg, result_next;
  logic [CHAN_W-1:0] actChan_reg, actChan_next;
  logic [CS_W-1:0] actCs_reg, actCs_next;
  logic actRef_reg, actRef_next;
  logic startEv, doneEv;

  // analog side outputs
  logic [NUM_CHAN-1:0] chanSel_reg, chanSel_next;
  logic posRef_reg, posRef_next;
  logic sample_reg, sample_next;
  logic [CHAN_W-1:0] selCode;
  logic halfTick, oscFault;

  sar_tick_gen tickGen (
    .clk_sys(clk_sys),
    .rstSyncN(rstSyncN),
    .run(state_reg != ST_IDLE),
    .clockSel(actCs_reg),
    .convOsc(convOsc),
    .sleeping(sleeping),
    .halfTick(halfTick),
    .oscFault(oscFault)
  );

  // bus: writes complete with no wait, reads take one wait state so that
  // hrdata comes from a flop and sees any write that just completed
  always_comb begin
    accept = hsel && htrans[HTRANS_ACT_BIT] && hready;
    wrPend_next = accept && hwrite && (hsize == HSIZE_WORD);
    rdPend_next = accept && !hwrite;
    addr_next = addr_reg;
    if (accept) begin
      // anything outside the low window answers as unmapped
      addr_next = (haddr[DW-1:AW] == '0) ? haddr[AW-1:0] : OFF_NONE;
    end
    readMux = '0;
    if (addr_reg == OFF_CTRL0) begin
      readMux[C0_EN_BIT] = enable_reg;
      readMux[C0_GO_BIT] = go_reg;
      readMux[C0_CHAN_LSB +: CHAN_W] = chan_reg;
    end else if (addr_reg == OFF_CTRL1) begin
      readMux[C1_CS_LSB +: CS_W] = cs_reg;
      readMux[C1_REF_BIT] = ref_reg;
    end else if (addr_reg == OFF_RES_HI) begin
      readMux[RES_HI_W-1:0] = result_reg[RES_W-1:RES_LO_W];
    end else if (addr_reg == OFF_RES_LO) begin
      readMux[RES_LO_W-1:0] = result_reg[RES_LO_W-1:0];
    end else if (addr_reg == OFF_IRQ_STAT) begin
      readMux[IRQ_W-1:0] = status_reg;
    end else if (addr_reg == OFF_IRQ_MASK) begin
      readMux[IRQ_W-1:0] = mask_reg;
    end
    hrdata_next = rdPend_reg ? readMux : hrdata_reg;
    wrCtrl0 = wrPend_reg && addr_reg == OFF_CTRL0;
    wrCtrl1 = wrPend_reg && addr_reg == OFF_CTRL1;
    wrMask = wrPend_reg && addr_reg == OFF_IRQ_MASK;
    rdClr = rdPend_reg && addr_reg == OFF_IRQ_STAT;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      addr_reg <= OFF_NONE;
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      hrdata_reg <= '0;
    end else begin
      addr_reg <= addr_next;
      wrPend_reg <= wrPend_next;
      rdPend_reg <= rdPend_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = !rdPend_reg;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_reg;

  // control and interrupt registers
  always_comb begin
    enable_next = enable_reg;
    go_next = go_reg;
    chan_next = chan_reg;
    cs_next = cs_reg;
    ref_next = ref_reg;
    mask_next = mask_reg;
    if (wrCtrl0) begin
      enable_next = hwdata[C0_EN_BIT];
      chan_next = hwdata[C0_CHAN_LSB +: CHAN_W];
      // a zero written to the start bit does not abort a running conversion
      go_next = go_reg || hwdata[C0_GO_BIT];
    end
    if (wrCtrl1) begin
      cs_next = hwdata[C1_CS_LSB +: CS_W];
      ref_next = hwdata[C1_REF_BIT];
    end
    if (wrMask) begin
      mask_next = hwdata[IRQ_W-1:0];
    end
    if (doneEv || !enable_next) begin
      go_next = 1'b0;
    end
    irqSet = '0;
    irqSet[IRQ_DONE] = doneEv;
    irqSet[IRQ_OSC] = oscFault;
    // an event in the cycle of the clearing read survives it
    status_next = (status_reg & ~{IRQ_W{rdClr}}) | irqSet;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      enable_reg <= 1'b0;
      go_reg <= 1'b0;
      chan_reg <= CHAN_RST;
      cs_reg <= CS_RST;
      ref_reg <= REF_RST;
      mask_reg <= IRQ_RST;
      status_reg <= IRQ_RST;
    end else begin
      enable_reg <= enable_next;
      go_reg <= go_next;
      chan_reg <= chan_next;
      cs_reg <= cs_next;
      ref_reg <= ref_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
    end
  end

  assign irq = |(status_reg & mask_reg);
  assign wakeReq = sleeping && irq;

  // conversion sequence, counted in half bit-periods
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    bitIdx_next = bitIdx_reg;
    sar_next = sar_reg;
    result_next = result_reg;
    startEv = 1'b0;
    doneEv = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (go_reg && enable_reg) begin
          startEv = 1'b1;
          phase_next = '0;
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (halfTick) begin
          phase_next = phase_reg + 1'b1;
          if (phase_reg == PH_HOLD_END) begin
            sar_next = SAR_FIRST;
            bitIdx_next = BIT_MSB;
            state_next = ST_RESOLVE;
          end
        end
      end
      ST_RESOLVE: begin
        if (halfTick) begin
          phase_next = phase_reg + 1'b1;
          if (phase_reg == PH_LAST) begin
            result_next = sar_reg;
            doneEv = 1'b1;
            state_next = ST_IDLE;
          end else if (phase_reg[0]) begin
            // decide the trial bit, then try the next lower one
            sar_next[bitIdx_reg] = compIn;
            if (bitIdx_reg != BIT_LSB) begin
              sar_next[bitIdx_reg - 1'b1] = 1'b1;
              bitIdx_next = bitIdx_reg - 1'b1;
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // clearing enable abandons a conversion; the old result stays
    if (!enable_reg) begin
      state_next = ST_IDLE;
    end
    actChan_next = startEv ? chan_reg : actChan_reg;
    actCs_next = startEv ? cs_reg : actCs_reg;
    actRef_next = startEv ? ref_reg : actRef_reg;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg <= ST_IDLE;
      phase_reg <= '0;
      bitIdx_reg <= BIT_MSB;
      sar_reg <= '0;
      result_reg <= '0;
      actChan_reg <= CHAN_RST;
      actCs_reg <= CS_RST;
      actRef_reg <= REF_RST;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bitIdx_reg <= bitIdx_next;
      sar_reg <= sar_next;
      result_reg <= result_next;
      actChan_reg <= actChan_next;
      actCs_reg <= actCs_next;
      actRef_reg <= actRef_next;
    end
  end

  // analog controls: while idle the mux tracks the live selection so that
  // acquisition runs ahead of the start; during a conversion it is frozen
  assign selCode = (state_next == ST_IDLE) ? chan_next : actChan_next;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : chanDecode
      if (g < NUM_PINS) begin : pinChan
        assign chanSel_next[g] = enable_next && PIN_MASK[g] && selCode == CHAN_W'(g);
      end else begin : intChan
        assign chanSel_next[g] = enable_next && selCode == CHAN_W'(g);
      end
    end
  endgenerate

  always_comb begin
    posRef_next = (state_next == ST_IDLE) ? ref_next : actRef_next;
    sample_next = enable_next && state_next == ST_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      chanSel_reg <= '0;
      posRef_reg <= REF_RST;
      sample_reg <= 1'b0;
    end else begin
      chanSel_reg <= chanSel_next;
      posRef_reg <= posRef_next;
      sample_reg <= sample_next;
    end
  end

  assign chanSel = chanSel_reg;
  assign posRefSel = posRef_reg;
  assign sampleEn = sample_reg;
  assign dacCode = sar_reg;
  assign busy = state_reg != ST_IDLE;

endmodule : sar_adc_sequencer

//--- verification/sar_adc_properties.sv
// sar_adc_properties: concurrent checks on the converter sequencer's ports.
// assumes a single clock domain and hready wired back from hreadyout.
`timescale 1ns/1ps
module sar_adc_properties (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [sar_adc_pkg::NUM_CHAN-1:0] chanSel,
  input wire logic posRefSel,
  input wire logic sampleEn,
  input wire logic [sar_adc_pkg::RES_W-1:0] dacCode,
  input wire logic busy,
  input wire logic irq,
  input wire logic sleeping,
  input wire logic wakeReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // fastest conversion is 23 half ticks of one clock, so shorter busy is wrong
  logic [11:0] busyCnt_reg, busyCnt_next;
  always_comb busyCnt_next = busy ? busyCnt_reg + 12'h1 : 12'h0;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) busyCnt_reg <= 12'h0;
    else busyCnt_reg <= busyCnt_next;
  property p_onehot; $onehot0(chanSel); endproperty
  a_onehot: assert property (p_onehot) else $error("mux select not one-hot");
  property p_selHold; busy && $past(busy) |-> $stable(chanSel) && $stable(posRefSel); endproperty
  a_selHold: assert property (p_selHold) else $error("select moved mid conversion");
  property p_holdOff; busy |-> !sampleEn; endproperty
  a_holdOff: assert property (p_holdOff) else $error("tracking while converting");
  property p_msbFirst; $rose(busy) |-> ##[1:400] dacCode == 10'h200; endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("first trial not msb");
  property p_minLen; $fell(busy) |-> busyCnt_reg >= 12'd23; endproperty
  a_minLen: assert property (p_minLen) else $error("conversion too short");
  property p_irqDone; $rose(irq) |-> !busy; endproperty
  a_irqDone: assert property (p_irqDone) else $error("irq while converting");
  property p_wake; irq && sleeping |-> ##[0:1] wakeReq; endproperty
  a_wake: assert property (p_wake) else $error("no wake request");
  property p_rdWait; hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rdWait: assert property (p_rdWait) else $error("read wait state wrong");
  c_conv: cover property ($fell(busy));
  c_wake: cover property (wakeReq);
  c_read: cover property (hsel && htrans[1] && !hwrite);
endmodule : sar_adc_properties

bind sar_adc_sequencer sar_adc_properties u_sar_adc_properties (
  .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .chanSel(chanSel), .posRefSel(posRefSel),
  .sampleEn(sampleEn), .dacCode(dacCode), .busy(busy), .irq(irq), .sleeping(sleeping),
  .wakeReq(wakeReq)
);

//--- verification/sar_analog_model.sv
// sar_analog_model: analog mux, sample-and-hold, comparator and oscillator.
// assumes level is held steady by the bench while a channel is tracked.
`timescale 1ns/1ps
module sar_analog_model (
  input wire logic clk_sys,
  input wire logic [15:0] chanSel,
  input wire logic sampleEn,
  input wire logic [9:0] dacCode,
  input wire logic [9:0] level,
  output logic compIn,
  output logic convOsc
);
  logic [9:0] held;
  int n;
  initial begin
    convOsc = 1'b0;
    n = 0;
    held = 10'h0;
  end
  // 100 clocks a half period: 1.6 us bit period, independent of the core
  always @(posedge clk_sys) begin
    n <= (n == 99) ? 0 : n + 1;
    if (n == 99) convOsc <= ~convOsc;
  end
  // track while sampling; an unselected mux reads as ground
  always @(posedge clk_sys) if (sampleEn) held <= (chanSel != 16'h0) ? level : 10'h0;
  // the input sits half a code above level, so the ideal code is level
  assign compIn = (held >= dacCode);
endmodule : sar_analog_model

//--- verification/tb.sv
// tb: self-checking bench driving the sequencer over its register port.
// assumes the analog model answers the comparator and runs the oscillator.
`timescale 1ns/1ps
module tb;
  import sar_adc_pkg::*;
  logic clk_sys, rstn, hsel, hwrite, sleeping, rf, mk;
  logic hreadyout, hresp, compIn, convOsc, posRefSel, sampleEn, busy, irq, wakeReq;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize, cs;
  logic [3:0] ch;
  logic [15:0] chanSel, expSel;
  logic [9:0] dacCode, level, expRes;
  logic [31:0] seed = 32'h0d53;
  logic [7:0] offs[7] = '{OFF_CTRL0, OFF_CTRL1, OFF_RES_HI, OFF_RES_LO, OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_NONE};
  int mismatches = 0, num_checks = 0, n, h, k;
  time tRise;

  sar_adc_sequencer u_sar_adc_sequencer (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .compIn(compIn), .convOsc(convOsc),
    .sleeping(sleeping), .chanSel(chanSel), .posRefSel(posRefSel), .sampleEn(sampleEn),
    .dacCode(dacCode), .busy(busy), .irq(irq), .wakeReq(wakeReq));
  sar_analog_model u_sar_analog_model (.clk_sys(clk_sys), .chanSel(chanSel), .sampleEn(sampleEn),
    .dacCode(dacCode), .level(level), .compIn(compIn), .convOsc(convOsc));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // ready and read data are both taken at the rising edge that ends the phase
  task automatic waitRdy();
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : waitRdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy();
  endtask : bus

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    sleeping = 1'b0;
    level = 10'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b1, OFF_RES_LO, 32'hffffffff);
    bus(1'b1, OFF_IRQ_STAT, 32'hffffffff);
    bus(1'b1, OFF_NONE, 32'hffffffff);
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      check(rd, 32'h0, "reset or read-only value");
    end
    $display("test reset values done");
    for (int r = 0; r < 24; r++) begin
      v = rnd();
      cs = r[2:0]; // all divisions swept: the comparator model has no settling limit
      ch = v[5:2];
      rf = v[8];
      mk = v[9];
      expRes = (r == 8) ? 10'h3ff : (r == 9) ? 10'h0 : v[19:10];
      level <= expRes;
      expSel = (ch >= 4'd14 || PIN_MASK[ch]) ? 16'h1 << ch : 16'h0;
      expRes = (expSel != 16'h0) ? expRes : 10'h0;
      h = (cs[1:0] == 2'b11) ? 100 : 1 << {cs[1:0], cs[2]};
      bus(1'b1, OFF_IRQ_MASK, 32'(mk) << IRQ_DONE);
      bus(1'b1, OFF_CTRL1, {27'h0, rf, 1'b0, cs});
      bus(1'b1, OFF_CTRL0, 32'({ch, 2'b01}));
      repeat (4) @(posedge clk_sys); // acquisition delay
      check(32'(chanSel), 32'(expSel), "channel select");
      check(32'(posRefSel), 32'(rf), "reference select");
      check(32'(sampleEn), 32'h1, "tracking before start");
      sleeping <= (cs[1:0] == 2'b11);
      bus(1'b1, OFF_CTRL0, 32'({ch, 2'b11}));
      n = 0;
      do begin
        @(posedge clk_sys);
        #1;
        n++;
      end while (busy !== 1'b1 && n < 9);
      tRise = $time;
      if (h >= 8) begin
        @(posedge clk_sys);
        bus(1'b1, OFF_CTRL0, 32'({~ch, 2'b01}));
        bus(1'b1, OFF_CTRL1, {27'h0, ~rf, 1'b0, ~cs});
        check(32'(chanSel), 32'(expSel), "select held while busy");
        check(32'(sampleEn), 32'h0, "held while converting");
      end
      #1;
      for (k = 0; k < 3000 && busy === 1'b1; k++) begin
        @(posedge clk_sys);
        #1;
      end
      n = int'(($time - tRise) / 8);
      if (h == 100) check(32'(n >= 22 * h && n <= 24 * h + 2), 32'h1, "osc conversion length");
      else check(32'(n), 32'(23 * h + 1), "divided conversion length");
      check(32'(irq), 32'(mk), "done interrupt");
      check(32'(wakeReq), 32'(mk & sleeping), "wake request");
      @(posedge clk_sys);
      sleeping <= 1'b0;
      bus(1'b0, OFF_RES_HI, 32'h0);
      check(rd, 32'(expRes[9:8]), "result high");
      bus(1'b0, OFF_RES_LO, 32'h0);
      check(rd, 32'(expRes[7:0]), "result low");
      check(32'(hresp), 32'(HRESP_OKAY), "okay response");
      bus(1'b0, OFF_CTRL0, 32'h0);
      check(32'(rd[C0_GO_BIT]), 32'h0, "start cleared");
      bus(1'b0, OFF_IRQ_STAT, 32'h0);
      check(rd, 32'h1 << IRQ_DONE, "done status");
      bus(1'b0, OFF_IRQ_STAT, 32'h0);
      check(rd, 32'h0, "status cleared by read");
      check(32'(irq), 32'h0, "irq after clear");
      $display("test conversion %0d done", r);
    end
    give_verdict();
  end

  initial begin
    #480000;
    mismatches++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule : tb
